// ### core/ect_pkg.sv
/*
 * Shared types and cost constants for the effective-address cycle
 * accounting block: addressing modes, instruction classes, the
 * (clocks, reads, writes) triple and the per-mode cost tables.
 * Assumes the sequencer supplies the mode and size codes given here.
 */
package ect_pkg;

  localparam int CLK_W = 8;
  localparam int CNT_W = 4;
  localparam int NUM_MODES = 12;

  // addressing modes, gray coded in table order
  typedef enum logic [3:0] {
    ECT_M_DREG    = 4'h0,
    ECT_M_AREG    = 4'h1,
    ECT_M_IND     = 4'h3,
    ECT_M_POSTINC = 4'h2,
    ECT_M_PREDEC  = 4'h6,
    ECT_M_DISP    = 4'h7,
    ECT_M_INDEX   = 4'h5,
    ECT_M_ABSW    = 4'h4,
    ECT_M_ABSL    = 4'hC,
    ECT_M_PCDISP  = 4'hD,
    ECT_M_PCINDEX = 4'hF,
    ECT_M_IMM     = 4'hE
  } ect_mode_t;

  // how the base count combines with the address cost
  typedef enum logic [1:0] {
    ECT_OP_MOVE     = 2'h0,
    ECT_OP_STD_PLUS = 2'h1,
    ECT_OP_STD_BARE = 2'h3,
    ECT_OP_XOR_DREG = 2'h2
  } ect_op_t;

  typedef struct packed {
    logic [CLK_W-1:0] clk;
    logic [CNT_W-1:0] rd;
    logic [CNT_W-1:0] wr;
  } ect_cost_t;

  typedef struct packed {
    logic      valid;
    ect_op_t   op;
    ect_mode_t mode;
    logic      is_long;
    logic      fetch;
    logic      idx_long;
    ect_cost_t base;
  } ect_req_t;

  typedef struct packed {
    logic      valid;
    logic      illegal;
    ect_cost_t ea;
    ect_cost_t total;
  } ect_rsp_t;

  localparam ect_cost_t ECT_ZERO = '{8'h00, 4'h0, 4'h0};

  // fetch costs, byte or word, indexed by table position
  localparam ect_cost_t ECT_FETCH_BW [NUM_MODES] = '{
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h04, 4'h1, 4'h0},
    '{8'h04, 4'h1, 4'h0}, '{8'h06, 4'h1, 4'h0}, '{8'h08, 4'h2, 4'h0},
    '{8'h0A, 4'h2, 4'h0}, '{8'h08, 4'h2, 4'h0}, '{8'h0C, 4'h3, 4'h0},
    '{8'h08, 4'h2, 4'h0}, '{8'h0A, 4'h2, 4'h0}, '{8'h04, 4'h1, 4'h0}};
  localparam ect_cost_t ECT_FETCH_L [NUM_MODES] = '{
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h08, 4'h2, 4'h0},
    '{8'h08, 4'h2, 4'h0}, '{8'h0A, 4'h2, 4'h0}, '{8'h0C, 4'h3, 4'h0},
    '{8'h0E, 4'h3, 4'h0}, '{8'h0C, 4'h3, 4'h0}, '{8'h10, 4'h4, 4'h0},
    '{8'h0C, 4'h3, 4'h0}, '{8'h0E, 4'h3, 4'h0}, '{8'h08, 4'h2, 4'h0}};
  localparam ect_cost_t ECT_NOFETCH_BW [NUM_MODES] = '{
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h02, 4'h0, 4'h0},
    '{8'h04, 4'h0, 4'h0}, '{8'h04, 4'h0, 4'h0}, '{8'h04, 4'h0, 4'h0},
    '{8'h08, 4'h1, 4'h0}, '{8'h04, 4'h1, 4'h0}, '{8'h08, 4'h2, 4'h0},
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}};
  localparam ect_cost_t ECT_NOFETCH_L [NUM_MODES] = '{
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h02, 4'h0, 4'h0},
    '{8'h04, 4'h0, 4'h0}, '{8'h04, 4'h0, 4'h0}, '{8'h04, 4'h1, 4'h0},
    '{8'h08, 4'h1, 4'h0}, '{8'h04, 4'h1, 4'h0}, '{8'h08, 4'h2, 4'h0},
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}};
  // modes that have a no-fetch form: register direct and memory only
  localparam logic [NUM_MODES-1:0] ECT_NOFETCH_OK = 12'h1FF;

  localparam ect_cost_t ECT_XOR_BW = '{8'h04, 4'h1, 4'h0};
  localparam ect_cost_t ECT_XOR_L  = '{8'h06, 4'h1, 4'h0};

endpackage

// ### core/ect_timing.sv
/*
 * Effective-address cycle accounting: one request per cycle in, one
 * registered answer one clock later with the address cost and the
 * instruction total as clock/read/write triples.
 * Assumes requests are synchronous to mclk; sums wrap at field width.
 */
`timescale 1ns/100ps

module ect_timing (
  input  wire logic           mclk,
  input  wire logic           sys_rst,
  input  ect_pkg::ect_req_t   req,
  output ect_pkg::ect_rsp_t   rsp
);

  ////////////////////////////////////////////////////////////////////////

  ect_pkg::ect_cost_t fetch_bw;
  ect_pkg::ect_cost_t fetch_l;
  ect_pkg::ect_cost_t nofetch_bw;
  ect_pkg::ect_cost_t nofetch_l;
  ect_pkg::ect_cost_t fetch_cost;
  ect_pkg::ect_cost_t nofetch_cost;
  ect_pkg::ect_cost_t ea_d;
  ect_pkg::ect_cost_t sum_cost;
  ect_pkg::ect_cost_t xor_cost;
  ect_pkg::ect_cost_t total_d;
  logic               nofetch_ok;
  logic               regdir;
  logic               illegal_d;
  logic [3:0]         idx;
  logic               valid_q;
  logic               illegal_q;
  ect_pkg::ect_cost_t ea_q;
  ect_pkg::ect_cost_t total_q;

  // table position from the gray-coded mode; a spare code lands on the
  // register-direct row so it can never claim bus cycles
  always_comb begin
    unique case (req.mode)
      ect_pkg::ECT_M_DREG:    idx = 4'h0;
      ect_pkg::ECT_M_AREG:    idx = 4'h1;
      ect_pkg::ECT_M_IND:     idx = 4'h2;
      ect_pkg::ECT_M_POSTINC: idx = 4'h3;
      ect_pkg::ECT_M_PREDEC:  idx = 4'h4;
      ect_pkg::ECT_M_DISP:    idx = 4'h5;
      ect_pkg::ECT_M_INDEX:   idx = 4'h6;
      ect_pkg::ECT_M_ABSW:    idx = 4'h7;
      ect_pkg::ECT_M_ABSL:    idx = 4'h8;
      ect_pkg::ECT_M_PCDISP:  idx = 4'h9;
      ect_pkg::ECT_M_PCINDEX: idx = 4'hA;
      ect_pkg::ECT_M_IMM:     idx = 4'hB;
      default:                idx = 4'h0;
    endcase
  end

  assign regdir = (req.mode == ect_pkg::ECT_M_DREG) ||
                  (req.mode == ect_pkg::ECT_M_AREG);

  ////////////////////////////////////////////////////////////////////////

  assign fetch_bw   = ect_pkg::ECT_FETCH_BW[idx];
  assign fetch_l    = ect_pkg::ECT_FETCH_L[idx];
  assign nofetch_bw = ect_pkg::ECT_NOFETCH_BW[idx];
  assign nofetch_l  = ect_pkg::ECT_NOFETCH_L[idx];
  // no-fetch column exists only for register and memory modes
  assign nofetch_ok = ect_pkg::ECT_NOFETCH_OK[idx];

  ////////////////////////////////////////////////////////////////////////

  always_comb begin
    if (req.is_long) begin
      fetch_cost   = fetch_l;
      nofetch_cost = nofetch_l;
    end else begin
      fetch_cost   = fetch_bw;
      nofetch_cost = nofetch_bw;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // address cost of the requested column
  always_comb begin
    if (req.fetch) begin
      ea_d = fetch_cost;
    end else begin
      ea_d = nofetch_cost;
    end
    if (regdir) begin
      ea_d = ect_pkg::ECT_ZERO;
    end
    ea_d.wr = '0;
  end

  ////////////////////////////////////////////////////////////////////////

  // an odd combination is flagged, not dropped: the costs still follow
  always_comb begin
    illegal_d = 1'b0;
    // pc-relative and immediate always read their operand
    if (!req.fetch && !nofetch_ok) begin
      illegal_d = 1'b1;
    end
    if (req.op == ect_pkg::ECT_OP_XOR_DREG &&
        req.mode != ect_pkg::ECT_M_DREG) begin
      illegal_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // per-field sum, wraps at field width
  always_comb begin
    sum_cost.clk = req.base.clk + ea_d.clk;
    sum_cost.rd  = req.base.rd + ea_d.rd;
    sum_cost.wr  = req.base.wr + ea_d.wr;
  end

  ////////////////////////////////////////////////////////////////////////

  always_comb begin
    if (req.is_long) begin
      xor_cost = ect_pkg::ECT_XOR_L;
    end else begin
      xor_cost = ect_pkg::ECT_XOR_BW;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // combine base and address cost by instruction class
  always_comb begin
    total_d = req.base;
    unique case (req.op)
      ect_pkg::ECT_OP_MOVE:     total_d = req.base;
      ect_pkg::ECT_OP_STD_PLUS: total_d = sum_cost;
      ect_pkg::ECT_OP_STD_BARE: total_d = req.base;
      ect_pkg::ECT_OP_XOR_DREG: total_d = xor_cost;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////

  // answer strobe, one clock after the request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= req.valid;
    end
  end

  // illegal flag only ever rides with the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= req.valid & illegal_d;
    end
  end

  // costs follow every cycle; read them only beside the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ea_q <= ect_pkg::ECT_ZERO;
    end else begin
      ea_q <= ea_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      total_q <= ect_pkg::ECT_ZERO;
    end else begin
      total_q <= total_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // outputs come straight from the flops
  always_comb begin
    rsp.valid   = valid_q;
    rsp.illegal = illegal_q;
    rsp.ea      = ea_q;
    rsp.total   = total_q;
  end

endmodule

// ### bench/ect_checker.sv
/* checker: port relations of the address cost block
   assumes bind onto ect_timing, one clock domain */
`timescale 1ns/100ps
module ect_checker (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input ect_pkg::ect_req_t req,
  input ect_pkg::ect_rsp_t rsp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ans_follows_a: assert property (req.valid |=> rsp.valid)
    else $error("answer missing");
  no_spur_a: assert property (!req.valid |=> !rsp.valid)
    else $error("spurious answer");
  ea_nowr_a: assert property (rsp.ea.wr == 4'h0)
    else $error("address cost writes");
  regdir_zero_a: assert property (req.valid && req.mode < 4'h2
    |=> rsp.ea == ect_pkg::ECT_ZERO) else $error("direct not zero");
  move_total_a: assert property (req.op == ect_pkg::ECT_OP_MOVE
    |=> rsp.total == $past(req.base)) else $error("move total");
  std_sum_a: assert property (req.op == ect_pkg::ECT_OP_STD_PLUS
    |=> rsp.total.rd == 4'($past(req.base.rd) + rsp.ea.rd))
    else $error("plus sum");
  xor_fixed_a: assert property (req.op == ect_pkg::ECT_OP_XOR_DREG
    |=> rsp.total.clk == ($past(req.is_long) ? 8'h06 : 8'h04))
    else $error("xor cost");
  ind_fetch_a: assert property (req.mode == ect_pkg::ECT_M_IND
    && req.fetch && !req.is_long |=> rsp.ea.clk == 8'h04
    && rsp.ea.rd == 4'h1) else $error("indirect cost");
  cover property (rsp.valid && rsp.illegal);
  cover property (req.valid ##1 req.valid);
  cover property (req.op == ect_pkg::ECT_OP_STD_PLUS && req.fetch);
endmodule
bind ect_timing ect_checker chk_i (.mclk(mclk), .sys_rst(sys_rst),
  .req(req), .rsp(rsp));

// ### bench/ect_bus_model.sv
/* far side: bus that runs the reads and writes of each answer
   assumes rsp of ect_timing; counters wrap at 8 bits */
`timescale 1ns/100ps
module ect_bus_model (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  ect_pkg::ect_rsp_t rsp,
  output logic [7:0]       rd_cnt,
  output logic [7:0]       wr_cnt
);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_cnt <= 8'h00;
      wr_cnt <= 8'h00;
    end else if (rsp.valid) begin
      rd_cnt <= rd_cnt + {4'h0, rsp.total.rd};
      wr_cnt <= wr_cnt + {4'h0, rsp.total.wr};
    end
  end
endmodule

// ### bench/tb.sv
/* random bench with integer model of the cost tables
   assumes answer one edge after each request */
`timescale 1ns/100ps
module tb;
  // nibble per mode code: fetch clk/rd, no-fetch clk/rd, long rd
  localparam logic [63:0] FC = 64'hA48C000086A84400;
  localparam logic [63:0] FR = 64'h2123000021221100;
  localparam logic [63:0] NC = 64'h0008000044842400;
  localparam logic [63:0] NR = 64'h0002000000110000;
  localparam logic [63:0] NL = 64'h0002000010110000;
  logic              mclk = 1'b0;
  logic              sys_rst = 1'b1;
  ect_pkg::ect_req_t  req = '0;
  ect_pkg::ect_rsp_t  rsp;
  ect_pkg::ect_cost_t e_ea, e_tot;
  logic              e_v = 1'b0, e_ill, e_x;
  logic [7:0]        m_rd, m_wr, s_rd, s_wr;
  int                miscompares = 0, cmp_count = 0;
  always #2.5 mclk = ~mclk;
  ect_timing dut (.mclk(mclk), .sys_rst(sys_rst), .req(req), .rsp(rsp));
  ect_bus_model bus (.mclk(mclk), .sys_rst(sys_rst), .rsp(rsp),
    .rd_cnt(m_rd), .wr_cnt(m_wr));
  task automatic chk(input logic ok, input string s);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, s);
    end
  endtask
  task automatic step(input ect_pkg::ect_req_t r);
    int c, d, m;
    @(posedge mclk);
    #1;
    chk(rsp.valid === e_v, "valid");
    if (e_v) begin
      chk(rsp.illegal === e_ill, "illegal");
      chk(rsp.ea === e_ea, "ea");
      chk(rsp.total === e_tot, "total");
    end
    m = r.mode * 4;
    c = r.fetch ? FC[m+:4] : NC[m+:4];
    d = r.fetch ? FR[m+:4] : (r.is_long ? NL[m+:4] : NR[m+:4]);
    if (r.fetch && r.is_long && r.mode > 1) begin
      c += 4;
      d += 1;
    end
    e_ea = {c[7:0], d[3:0], 4'h0};
    e_x = r.op == ect_pkg::ECT_OP_XOR_DREG;
    e_ill = (!r.fetch && r.mode > 4'hC) || (e_x && r.mode != 4'h0);
    e_tot = r.base;
    if (r.op == ect_pkg::ECT_OP_STD_PLUS) begin
      e_tot.clk = r.base.clk + c[7:0];
      e_tot.rd = r.base.rd + d[3:0];
    end
    if (e_x)
      e_tot = {r.is_long ? 8'h06 : 8'h04, 4'h1, 4'h0};
    e_v = r.valid;
    if (e_v) begin
      s_rd += {4'h0, e_tot.rd};
      s_wr += {4'h0, e_tot.wr};
    end
    req = r;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    ect_pkg::ect_req_t r;
    int k;
    void'($urandom(49604));
    repeat (2) begin
      sys_rst = 1'b1;
      req.valid = 1'b1;
      repeat (3) @(posedge mclk);
      #1 chk(rsp === '0, "reset");
      sys_rst = 1'b0;
      req = '0;
      {e_v, s_rd, s_wr} = '0;
      for (int i = 0; i < 400; i++) begin
        r = $bits(r)'($urandom);
        k = $urandom_range(11);
        r.mode = ect_pkg::ect_mode_t'(k < 8 ? k : k + 4);
        r.valid = $urandom_range(3) != 0;
        step(r);
      end
      repeat (2) step('0);
      chk(m_rd === s_rd && m_wr === s_wr, "bus sums");
    end
    tally_and_finish();
  end
endmodule
